// [logic/wlv_core.sv]
// Purpose: Device-side write leveling, mode registers and power-up termination control
// Assumes: CK and all pins are sampled by mclk; CK is much slower than mclk
// Notes:   Data pins use active-low output enables
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module wlv_core #(
  parameter int LANES = wlv_pkg::LANES
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [wlv_pkg::WB_AW-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       ck_pin,
  input  wire logic [LANES-1:0]           dqs_pin,
  input  wire logic                       reset_pin_n,
  input  wire logic                       cke_pin,
  input  wire logic                       odt_pin,
  input  wire logic                       cs_pin_n,
  input  wire logic                       ras_pin_n,
  input  wire logic                       cas_pin_n,
  input  wire logic                       we_pin_n,
  input  wire logic [wlv_pkg::BA_W-1:0]   ba_pin,
  input  wire logic [wlv_pkg::ADDR_W-1:0] addr_pin,
  output logic      [LANES*wlv_pkg::LANE_W-1:0] dq_o,
  output logic      [LANES*wlv_pkg::LANE_W-1:0] dq_oe_n,
  output logic                            term_on
);
  localparam int DW = LANES * wlv_pkg::LANE_W;
  localparam int SW = LANES + 8 + wlv_pkg::BA_W + wlv_pkg::ADDR_W;

  if (LANES < 1 || LANES > 8) begin : g_bad_lanes
    $error("wlv_core supports 1 to 8 byte lanes");
  end

  // Pin synchronisation
  logic [SW-1:0] pins_s;
  wlv_sync #(.W(SW)) u_sync (
    .mclk (mclk),
    .rst_n(rst_n),
    .pin  ({ck_pin, reset_pin_n, cke_pin, odt_pin, cs_pin_n, ras_pin_n, cas_pin_n, we_pin_n,
            ba_pin, addr_pin, dqs_pin}),
    .sync (pins_s)
  );

  logic                       ck_s;
  logic                       dev_rst_n_s;
  logic                       cke_s;
  logic                       odt_s;
  logic [3:0]                 cmd_s;
  logic [wlv_pkg::BA_W-1:0]   ba_s;
  logic [wlv_pkg::ADDR_W-1:0] addr_s;
  logic [LANES-1:0]           dqs_s;
  assign {ck_s, dev_rst_n_s, cke_s, odt_s, cmd_s, ba_s, addr_s, dqs_s} = pins_s;

  // Edge detection on CK and strobes
  logic             ck_prev_q;
  logic [LANES-1:0] dqs_prev_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ck_prev_q  <= 1'b0;
      dqs_prev_q <= '0;
    end else begin
      ck_prev_q  <= ck_s;
      dqs_prev_q <= dqs_s;
    end
  end
  logic             ck_rise;
  logic [LANES-1:0] dqs_rise;
  assign ck_rise  = ck_s & ~ck_prev_q;
  assign dqs_rise = dqs_s & ~dqs_prev_q;

  // Mode register set: all four command pins low at a CK rise with CKE high
  logic mrs;
  assign mrs = ck_rise & cke_s & (cmd_s == 4'h0);

  // CKE registered high at least once since device reset
  logic cke_seen_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cke_seen_q <= 1'b0;
    end else if (!dev_rst_n_s) begin
      cke_seen_q <= 1'b0;
    end else if (ck_rise && cke_s) begin
      cke_seen_q <= 1'b1;
    end
  end

  // Mode registers
  logic [wlv_pkg::ADDR_W-1:0] mr_q [4];
  logic                       dll_start;
  assign dll_start = mrs && (ba_s[1:0] == wlv_pkg::MR_SEL_0) && addr_s[wlv_pkg::MR0_DLLRST_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) mr_q[i] <= '0;
    end else if (!dev_rst_n_s) begin
      for (int i = 0; i < 4; i++) mr_q[i] <= '0;
    end else if (mrs) begin
      mr_q[ba_s[1:0]] <= addr_s;
    end else if (mr_q[0][wlv_pkg::MR0_DLLRST_BIT]) begin
      mr_q[0][wlv_pkg::MR0_DLLRST_BIT] <= 1'b0;
    end
  end

  // DLL lock timer counted in CK cycles
  localparam logic [wlv_pkg::DLL_CW-1:0] DLL_LAST = wlv_pkg::DLL_CW'(wlv_pkg::DLLK_CK - 1);
  logic [wlv_pkg::DLL_CW-1:0] dll_cnt_q;
  logic                       dll_locked_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dll_cnt_q    <= '0;
      dll_locked_q <= 1'b0;
    end else if (!dev_rst_n_s) begin
      dll_cnt_q    <= '0;
      dll_locked_q <= 1'b0;
    end else if (dll_start) begin
      dll_cnt_q    <= '0;
      dll_locked_q <= 1'b0;
    end else if (ck_rise && !dll_locked_q) begin
      if (dll_cnt_q == DLL_LAST) begin
        dll_locked_q <= 1'b1;
      end else begin
        dll_cnt_q <= dll_cnt_q + 1'b1;
      end
    end
  end

  // Software control register
  logic                       ctrl_dis_q;
  logic [wlv_pkg::TMOD_W-1:0] tmod_ck_q;
  logic                       wb_req;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_dis_q <= 1'b0;
      tmod_ck_q  <= wlv_pkg::TMOD_CK_RESET;
    end else if (wb_req && wb_we_i && wb_adr_i == wlv_pkg::OFS_CTRL) begin
      if (wb_sel_i[0]) ctrl_dis_q <= wb_dat_i[wlv_pkg::CTRL_DIS_BIT];
      if (wb_sel_i[1]) tmod_ck_q <= wb_dat_i[wlv_pkg::CTRL_TMOD_LSB +: wlv_pkg::TMOD_W];
    end
  end

  // Leveling state: leveling, then tMOD hold after the clearing command
  logic                       wl_en;
  logic                       qoff;
  wlv_pkg::wlv_state_type     state_q;
  logic [wlv_pkg::TMOD_W-1:0] hold_q;
  assign wl_en = mr_q[1][wlv_pkg::MR1_WL_BIT];
  assign qoff  = mr_q[1][wlv_pkg::MR1_QOFF_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= wlv_pkg::WLV_IDLE;
      hold_q  <= '0;
    end else if (!dev_rst_n_s) begin
      state_q <= wlv_pkg::WLV_IDLE;
      hold_q  <= '0;
    end else begin
      case (state_q)
        wlv_pkg::WLV_IDLE: begin
          if (wl_en) state_q <= wlv_pkg::WLV_LEVEL;
        end
        wlv_pkg::WLV_LEVEL: begin
          if (!wl_en) begin
            state_q <= wlv_pkg::WLV_EXIT;
            hold_q  <= tmod_ck_q;
          end
        end
        wlv_pkg::WLV_EXIT: begin
          if (wl_en) begin
            state_q <= wlv_pkg::WLV_LEVEL;
          end else if (hold_q == '0) begin
            state_q <= wlv_pkg::WLV_IDLE;
          end else if (ck_rise) begin
            hold_q <= hold_q - 1'b1;
          end
        end
        default: state_q <= wlv_pkg::WLV_IDLE;
      endcase
    end
  end

  // Data pins driven while leveling or during the exit hold, unless outputs are off in MR1 or disabled in the control register
  logic drive_d;
  assign drive_d = (state_q != wlv_pkg::WLV_IDLE) && !qoff && !ctrl_dis_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dq_oe_n <= '1;
    end else begin
      dq_oe_n <= {DW{~drive_d}};
    end
  end

  // Per-lane CK capture on the lane's strobe rise
  logic [LANES-1:0] level_bits;
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        dq_o[l*wlv_pkg::LANE_W +: wlv_pkg::LANE_W] <= '0;
      end else if (state_q != wlv_pkg::WLV_LEVEL) begin
        dq_o[l*wlv_pkg::LANE_W +: wlv_pkg::LANE_W] <= '0;
      end else if (dqs_rise[l]) begin
        dq_o[l*wlv_pkg::LANE_W +: wlv_pkg::LANE_W] <= {{(wlv_pkg::LANE_W-1){1'b0}}, ck_s};
      end
    end
    assign level_bits[l] = dq_o[l*wlv_pkg::LANE_W];
  end

  // Nominal termination: off until CKE seen, off whenever disabled in MR1
  logic nom_en;
  assign nom_en = mr_q[1][wlv_pkg::MR1_NOM0_BIT] | mr_q[1][wlv_pkg::MR1_NOM1_BIT]
                | mr_q[1][wlv_pkg::MR1_NOM2_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      term_on <= 1'b0;
    end else begin
      term_on <= dev_rst_n_s && cke_seen_q && nom_en && odt_s;
    end
  end

  // Wishbone slave: ack one cycle after request, unmapped reads give zero
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0;
    case (wb_adr_i)
      wlv_pkg::OFS_CTRL: begin
        rd_d[wlv_pkg::CTRL_DIS_BIT] = ctrl_dis_q;
        rd_d[wlv_pkg::CTRL_TMOD_LSB +: wlv_pkg::TMOD_W] = tmod_ck_q;
      end
      wlv_pkg::OFS_STAT: begin
        rd_d[wlv_pkg::STAT_LEVEL_BIT] = (state_q == wlv_pkg::WLV_LEVEL);
        rd_d[wlv_pkg::STAT_DRIVE_BIT] = ~dq_oe_n[0];
        rd_d[wlv_pkg::STAT_LOCK_BIT]  = dll_locked_q;
        rd_d[wlv_pkg::STAT_CKE_BIT]   = cke_seen_q;
        rd_d[wlv_pkg::STAT_TERM_BIT]  = term_on;
      end
      wlv_pkg::OFS_MR0:   rd_d[wlv_pkg::ADDR_W-1:0] = mr_q[0];
      wlv_pkg::OFS_MR1:   rd_d[wlv_pkg::ADDR_W-1:0] = mr_q[1];
      wlv_pkg::OFS_MR2:   rd_d[wlv_pkg::ADDR_W-1:0] = mr_q[2];
      wlv_pkg::OFS_MR3:   rd_d[wlv_pkg::ADDR_W-1:0] = mr_q[3];
      wlv_pkg::OFS_LEVEL: rd_d[LANES-1:0] = level_bits;
      default:            rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_d : 32'h0;
    end
  end

  // Checks
  sequence dqs_edge_s(int l);
    (state_q == wlv_pkg::WLV_LEVEL) && dqs_rise[l] && wl_en;
  endsequence

  prime_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dqs_edge_s(0) |=> dq_o[0] == $past(ck_s))
    else $error("prime bit does not follow sampled CK");

  prime_timing_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dqs_edge_s(LANES-1) ##1 (state_q == wlv_pkg::WLV_LEVEL) |-> level_bits[LANES-1] == $past(ck_s))
    else $error("prime bit late after strobe rise");

  other_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dq_o[wlv_pkg::LANE_W-1:1] == '0 && dq_o[DW-1 -: wlv_pkg::LANE_W-1] == '0)
    else $error("non-prime data bit driven high");

  nom_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !nom_en && $stable(mr_q[1]) |=> !term_on)
    else $error("termination on while nominal disabled");

  odt_hiz_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cke_seen_q |=> !term_on)
    else $error("termination on before CKE registered");

  dq_enter_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(state_q == wlv_pkg::WLV_LEVEL) && !qoff && !ctrl_dis_q |=> dq_oe_n == '0)
    else $error("data pins not driven on leveling entry");

  sequence exit_s;
    (state_q == wlv_pkg::WLV_LEVEL) ##1 (state_q == wlv_pkg::WLV_EXIT) && !qoff && !ctrl_dis_q;
  endsequence

  exit_hold_a: assert property (@(posedge mclk) disable iff (!rst_n || !dev_rst_n_s)
    exit_s ##1 (hold_q != '0) |-> dq_oe_n == '0)
    else $error("data pins released before tMOD hold");

  mr0_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dll_start ##1 !mrs |=> !mr_q[0][wlv_pkg::MR0_DLLRST_BIT])
    else $error("DLL reset bit did not self-clear");

  dll_lock_a: assert property (@(posedge mclk) disable iff (!rst_n)
    dll_locked_q |-> dll_cnt_q == DLL_LAST)
    else $error("DLL locked before 512 clocks");

  mr_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !dev_rst_n_s |=> mr_q[1] == '0 && !dll_locked_q)
    else $error("mode registers kept through device reset");
endmodule : wlv_core

// [logic/wlv_sync.sv]
// Purpose: Two-stage synchroniser for a vector of pin inputs
// Assumes: Bits are sampled independently
// Notes:   Only the second stage is visible outside
`timescale 1ns/100ps
module wlv_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] sync
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_bad_width
    $error("wlv_sync width must be positive");
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync   <= '0;
    end else begin
      meta_q <= pin;
      sync   <= meta_q;
    end
  end
endmodule : wlv_sync

// [pkg/wlv_pkg.sv]
// Purpose: Shared constants and types for the write-leveling and init model
// Assumes: Mode registers are addressed by the low two bank bits
// Notes:   All pin figures are in command clock (CK) cycles
package wlv_pkg;
  localparam int ADDR_W  = 13;
  localparam int BA_W    = 3;
  localparam int LANE_W  = 8;
  localparam int LANES   = 8;
  localparam int DQ_W    = LANES * LANE_W;
  localparam int WB_AW   = 8;

  // Register byte offsets
  localparam logic [WB_AW-1:0] OFS_CTRL  = 8'h00;
  localparam logic [WB_AW-1:0] OFS_STAT  = 8'h04;
  localparam logic [WB_AW-1:0] OFS_MR0   = 8'h08;
  localparam logic [WB_AW-1:0] OFS_MR1   = 8'h0c;
  localparam logic [WB_AW-1:0] OFS_MR2   = 8'h10;
  localparam logic [WB_AW-1:0] OFS_MR3   = 8'h14;
  localparam logic [WB_AW-1:0] OFS_LEVEL = 8'h18;

  // Control register fields
  localparam int CTRL_DIS_BIT  = 0;
  localparam int CTRL_TMOD_LSB = 8;
  localparam int TMOD_W        = 8;
  localparam logic [TMOD_W-1:0] TMOD_CK_RESET = 8'h0c;

  // Status register fields
  localparam int STAT_LEVEL_BIT = 0;
  localparam int STAT_DRIVE_BIT = 1;
  localparam int STAT_LOCK_BIT  = 2;
  localparam int STAT_CKE_BIT   = 3;
  localparam int STAT_TERM_BIT  = 4;

  // Mode register fields
  localparam int MR0_DLLRST_BIT = 8;
  localparam int MR1_NOM0_BIT   = 2;
  localparam int MR1_NOM1_BIT   = 6;
  localparam int MR1_WL_BIT     = 7;
  localparam int MR1_NOM2_BIT   = 9;
  localparam int MR1_QOFF_BIT   = 12;
  localparam logic [1:0] MR_SEL_0 = 2'h0;
  localparam logic [1:0] MR_SEL_1 = 2'h1;

  // DLL lock time in CK cycles
  localparam int DLLK_CK = 512;
  localparam int DLL_CW  = 10;

  typedef enum logic [1:0] {
    WLV_IDLE,
    WLV_LEVEL,
    WLV_EXIT
  } wlv_state_type;
endpackage : wlv_pkg

// [testbench/dram_write_level_init_tb.sv]
// Purpose: Self-checking bench for the device-side leveling logic
// Assumes: Classic Wishbone single cycles; ack within 50 cycles
// Notes:   One task per scenario, each judges its own outcome
`timescale 1ns/100ps
module dram_write_level_init_tb;
  logic        mclk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        ck_pin, reset_pin_n, cke_pin, odt_pin, cs_pin_n, ras_pin_n, cas_pin_n, we_pin_n, term_on;
  logic [7:0]  dqs_pin;
  logic [2:0]  ba_pin;
  logic [12:0] addr_pin;
  logic [63:0] dq_o, dq_oe_n;
  int          err_count, checked, cycles;

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  wlv_core dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ck_pin(ck_pin), .dqs_pin(dqs_pin), .reset_pin_n(reset_pin_n), .cke_pin(cke_pin), .odt_pin(odt_pin),
    .cs_pin_n(cs_pin_n), .ras_pin_n(ras_pin_n), .cas_pin_n(cas_pin_n), .we_pin_n(we_pin_n), .ba_pin(ba_pin),
    .addr_pin(addr_pin), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .term_on(term_on));

  wlv_ctl_model m (.mclk(mclk), .ck_pin(ck_pin), .dqs_pin(dqs_pin), .reset_pin_n(reset_pin_n),
    .cke_pin(cke_pin), .odt_pin(odt_pin), .cs_pin_n(cs_pin_n), .ras_pin_n(ras_pin_n), .cas_pin_n(cas_pin_n),
    .we_pin_n(we_pin_n), .ba_pin(ba_pin), .addr_pin(addr_pin));

  task report_and_stop();
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk("wb_ack", 64'h1, 64'h0);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_cycle

  task t_regs();
    chk("oe_reset", {64{1'b1}}, dq_oe_n);
    chk("term_reset", 64'h0, term_on);
    wb_cycle(1'b0, wlv_pkg::OFS_CTRL, 32'h0, 4'hf);
    chk("ctrl_reset", 64'h00000c00, rd);
    wb_cycle(1'b1, wlv_pkg::OFS_STAT, 32'hffffffff, 4'hf);
    wb_cycle(1'b0, wlv_pkg::OFS_STAT, 32'h0, 4'hf);
    chk("stat_ro", 64'h0, rd);
    wb_cycle(1'b1, 8'hfc, 32'hffffffff, 4'hf);
    wb_cycle(1'b0, 8'hfc, 32'h0, 4'hf);
    chk("unmapped", 64'h0, rd);
    wb_cycle(1'b1, wlv_pkg::OFS_CTRL, 32'h00000601, 4'h3);
    wb_cycle(1'b1, wlv_pkg::OFS_CTRL, 32'h0000ff00, 4'h1);
    wb_cycle(1'b0, wlv_pkg::OFS_CTRL, 32'h0, 4'hf);
    chk("ctrl_sel", 64'h00000600, rd);
    wb_cycle(1'b1, wlv_pkg::OFS_CTRL, 32'h00000c00, 4'h3);
  endtask : t_regs

  task t_init();
    m.hold_reset(1'b1);
    chk("term_in_reset", 64'h0, term_on);
    m.release_reset();
    m.mrs(2'h2, 13'h0018);
    m.mrs(2'h3, 13'h0000);
    m.mrs(2'h1, 13'h0004);
    m.mrs(2'h0, 13'h0120);
    wb_cycle(1'b0, wlv_pkg::OFS_MR2, 32'h0, 4'hf);
    chk("mr2", 64'h0018, rd);
    wb_cycle(1'b0, wlv_pkg::OFS_MR1, 32'h0, 4'hf);
    chk("mr1", 64'h0004, rd);
    wb_cycle(1'b0, wlv_pkg::OFS_MR0, 32'h0, 4'hf);
    chk("mr0_selfclear", 64'h0020, rd);
    repeat (490 * 8) @(posedge mclk);
    wb_cycle(1'b0, wlv_pkg::OFS_STAT, 32'h0, 4'hf);
    chk("dll_early", 64'h8, rd[3:2] << 2);
    repeat (30 * 8) @(posedge mclk);
    wb_cycle(1'b0, wlv_pkg::OFS_STAT, 32'h0, 4'hf);
    chk("dll_locked", 64'h1, rd[wlv_pkg::STAT_LOCK_BIT]);
    m.set_odt(1'b1);
    repeat (6) @(posedge mclk);
    chk("term_on", 64'h1, term_on);
    m.set_odt(1'b0);
    repeat (6) @(posedge mclk);
    chk("term_off", 64'h0, term_on);
  endtask : t_init

  task t_term_off();
    m.mrs(2'h1, 13'h0000);
    m.set_odt(1'b1);
    repeat (6) @(posedge mclk);
    chk("term_disabled", 64'h0, term_on);
    m.set_odt(1'b0);
  endtask : t_term_off

  task t_level();
    m.mrs(2'h1, 13'h0080);
    repeat (4) @(posedge mclk);
    chk("oe_level", 64'h0, dq_oe_n);
    m.strobe(8'hff, 6);
    chk("ck_low", 64'h0, dq_o);
    m.strobe(8'hff, 2);
    chk("ck_high", 64'h0101010101010101, dq_o);
    m.strobe(8'h05, 6);
    chk("lane_split", 64'h0101010101000100, dq_o);
    wb_cycle(1'b0, wlv_pkg::OFS_LEVEL, 32'h0, 4'hf);
    chk("level_reg", 64'hfa, rd);
    m.mrs(2'h1, 13'h0000);
    chk("exit_oe", 64'h0, dq_oe_n);
    chk("exit_dq", 64'h0, dq_o);
    repeat (10 * 8) @(posedge mclk);
    chk("exit_hold", 64'h0, dq_oe_n);
    repeat (4 * 8) @(posedge mclk);
    chk("exit_release", {64{1'b1}}, dq_oe_n);
  endtask : t_level

  task t_refuse();
    m.mrs(2'h1, 13'h1080);
    repeat (4) @(posedge mclk);
    chk("qoff_oe", {64{1'b1}}, dq_oe_n);
    m.mrs(2'h1, 13'h0000);
    wb_cycle(1'b1, wlv_pkg::OFS_CTRL, 32'h00000c01, 4'h3);
    m.mrs(2'h1, 13'h0080);
    repeat (4) @(posedge mclk);
    chk("ctrl_dis_oe", {64{1'b1}}, dq_oe_n);
    m.mrs(2'h1, 13'h0000);
    wb_cycle(1'b1, wlv_pkg::OFS_CTRL, 32'h00000c00, 4'h3);
  endtask : t_refuse

  task t_dev_reset();
    m.mrs(2'h1, 13'h0004);
    m.set_odt(1'b1);
    repeat (6) @(posedge mclk);
    chk("term_pre_reset", 64'h1, term_on);
    m.hold_reset(1'b1);
    chk("term_dev_reset", 64'h0, term_on);
    wb_cycle(1'b0, wlv_pkg::OFS_STAT, 32'h0, 4'hf);
    chk("cke_seen_clr", 64'h0, rd[wlv_pkg::STAT_CKE_BIT]);
    wb_cycle(1'b0, wlv_pkg::OFS_MR1, 32'h0, 4'hf);
    chk("mr1_dev_reset", 64'h0, rd);
  endtask : t_dev_reset

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    err_count = 0;
    checked   = 0;
    rst_n     = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i  = 8'h00;
    wb_sel_i  = 4'h0;
    wb_dat_i  = 32'h0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_init();
    t_term_off();
    t_level();
    t_refuse();
    t_dev_reset();
    report_and_stop();
  end
endmodule : dram_write_level_init_tb

// [testbench/wlv_ctl_model.sv]
// Purpose: Controller-side pin driver for the write-leveling device logic
// Assumes: Pins change just after an mclk rise; CK runs free at 200 ns
// Notes:   Reset and CKE hold times are shortened by parameters
`timescale 1ns/100ps
module wlv_ctl_model #(
  parameter int RST_MCLK = 40,
  parameter int CKE_MCLK = 40
) (
  input  wire logic                       mclk,
  output logic                            ck_pin,
  output logic [7:0]                      dqs_pin,
  output logic                            reset_pin_n,
  output logic                            cke_pin,
  output logic                            odt_pin,
  output logic                            cs_pin_n,
  output logic                            ras_pin_n,
  output logic                            cas_pin_n,
  output logic                            we_pin_n,
  output logic [wlv_pkg::BA_W-1:0]        ba_pin,
  output logic [wlv_pkg::ADDR_W-1:0]      addr_pin
);
  // Command clock, free running, phase unrelated to mclk
  initial begin
    ck_pin = 1'b0;
    #37;
    forever #100 ck_pin = ~ck_pin;
  end

  initial begin
    dqs_pin     = 8'h00;
    reset_pin_n = 1'b0;
    cke_pin     = 1'b0;
    odt_pin     = 1'b0;
    {cs_pin_n, ras_pin_n, cas_pin_n, we_pin_n} = 4'hf;
    ba_pin      = 3'h0;
    addr_pin    = 13'h0000;
  end

  task hold_reset(input logic odt);
    @(posedge mclk);
    reset_pin_n <= 1'b0;
    cke_pin     <= 1'b0;
    odt_pin     <= odt;
    repeat (RST_MCLK) @(posedge mclk);
  endtask : hold_reset

  task release_reset();
    odt_pin <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_pin_n <= 1'b1;
    repeat (CKE_MCLK) @(posedge mclk);
    cke_pin <= 1'b1;
    repeat (40) @(posedge mclk);
  endtask : release_reset

  task set_odt(input logic v);
    @(posedge mclk);
    odt_pin <= v;
  endtask : set_odt

  // Mode command set up after CK fall, held past the next CK rise
  task mrs(input logic [1:0] sel, input logic [12:0] val);
    @(negedge ck_pin);
    @(posedge mclk);
    {cs_pin_n, ras_pin_n, cas_pin_n, we_pin_n} <= 4'h0;
    ba_pin   <= {1'b0, sel};
    addr_pin <= val;
    @(posedge ck_pin);
    repeat (5) @(posedge mclk);
    {cs_pin_n, ras_pin_n, cas_pin_n, we_pin_n} <= 4'hf;
    ba_pin   <= ~ba_pin;
    addr_pin <= ~addr_pin;
    repeat (8) @(posedge mclk);
  endtask : mrs

  // One strobe toggle placed dly mclk after a CK rise
  task strobe(input logic [7:0] lanes, input int dly);
    @(posedge ck_pin);
    repeat (dly) @(posedge mclk);
    dqs_pin <= lanes;
    repeat (3) @(posedge mclk);
    dqs_pin <= 8'h00;
    repeat (6) @(posedge mclk);
  endtask : strobe
endmodule : wlv_ctl_model
